// ===== rtl/ctm_pkg.sv
// ----------------------------------------------------------------
// Compact timer shared definitions
// ----------------------------------------------------------------
package ctm_pkg;

   // Counter and byte geometry
   localparam int CTM_CNT_W = 10;
   localparam int CTM_PER_W = 3;
   localparam logic [9:0] CTM_CNT_MAX = 10'h03FF;

   // Register byte offsets on the APB bus
   localparam logic [7:0] CTM_OFS_CTRL0 = 8'h00;
   localparam logic [7:0] CTM_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] CTM_OFS_CNT_LO = 8'h08;
   localparam logic [7:0] CTM_OFS_CNT_HI = 8'h0C;
   localparam logic [7:0] CTM_OFS_CMPA_LO = 8'h10;
   localparam logic [7:0] CTM_OFS_CMPA_HI = 8'h14;

   // Reset values
   localparam logic [7:0] CTM_CTRL_RST = 8'h00;
   localparam logic [9:0] CTM_CMPA_RST = 10'h000;

   // Prescaler ratios for the internal sources
   localparam int CTM_SYS_DIV = 4;
   localparam int CTM_HI_DIV_A = 16;
   localparam int CTM_HI_DIV_B = 64;

   // Clock source select codes
   localparam logic [2:0] CTM_CK_SYS4 = 3'h0;
   localparam logic [2:0] CTM_CK_SYS = 3'h1;
   localparam logic [2:0] CTM_CK_H16 = 3'h2;
   localparam logic [2:0] CTM_CK_H64 = 3'h3;
   localparam logic [2:0] CTM_CK_SUB0 = 3'h4;
   localparam logic [2:0] CTM_CK_SUB1 = 3'h5;
   localparam logic [2:0] CTM_CK_EXT_R = 3'h6;
   localparam logic [2:0] CTM_CK_EXT_F = 3'h7;

   // Output action codes
   localparam logic [1:0] CTM_IO_KEEP = 2'h0;
   localparam logic [1:0] CTM_IO_LOW = 2'h1;
   localparam logic [1:0] CTM_IO_HIGH = 2'h2;
   localparam logic [1:0] CTM_IO_TOGGLE = 2'h3;

   // Operating modes
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TIMER = 2'h3
   } ctm_mode_t;

   // Control byte 0
   typedef struct packed {
      logic pause;
      logic [2:0] clk_sel;
      logic on;
      logic [2:0] period;
   } ctm_ctrl0_t;

   // Control byte 1
   typedef struct packed {
      ctm_mode_t mode;
      logic [1:0] io;
      logic init_level;
      logic invert;
      logic dpx;
      logic clr_sel;
   } ctm_ctrl1_t;

endpackage : ctm_pkg

// ===== rtl/ctm_tick_gen.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Count tick source selection
// ----------------------------------------------------------------
module ctm_tick_gen
   import ctm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Selection
   input wire logic [2:0] clk_sel,
   // Clock sources
   input wire logic high_clk_tick,
   input wire logic sub_clk_tick,
   input wire logic compact_ext_clock_pin,
   // Result
   output logic count_tick
);

   logic [1:0] sys_div_reg;
   logic [5:0] hi_div_reg;
   logic pin_prev_reg;
   logic pin_rise;
   logic pin_fall;
   logic tick_next;

   // Free-running prescalers; they never stop so ratios stay exact
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sys_div_reg <= 2'h0;
         hi_div_reg <= 6'h00;
      end
      else
      begin
         sys_div_reg <= sys_div_reg + 2'h1;
         if (high_clk_tick)
            hi_div_reg <= hi_div_reg + 6'h01;
      end
   end

   // Previous pin level for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_prev_reg <= 1'b0;
      else
         pin_prev_reg <= compact_ext_clock_pin;
   end

   assign pin_rise = compact_ext_clock_pin & ~pin_prev_reg;
   assign pin_fall = ~compact_ext_clock_pin & pin_prev_reg;

   // Source multiplexer
   always_comb
   begin
      unique case (clk_sel)
         CTM_CK_SYS4: tick_next = (sys_div_reg == 2'(CTM_SYS_DIV - 1));
         CTM_CK_SYS: tick_next = 1'b1;
         CTM_CK_H16: tick_next = high_clk_tick && (hi_div_reg[3:0] == 4'(CTM_HI_DIV_A - 1));
         CTM_CK_H64: tick_next = high_clk_tick && (hi_div_reg == 6'(CTM_HI_DIV_B - 1));
         CTM_CK_SUB0, CTM_CK_SUB1: tick_next = sub_clk_tick;
         CTM_CK_EXT_R: tick_next = pin_rise;
         CTM_CK_EXT_F: tick_next = pin_fall;
      endcase
   end

   // Registered tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_tick <= 1'b0;
      else
         count_tick <= tick_next;
   end

   ext_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_sel == CTM_CK_EXT_R) && pin_rise |=> count_tick)
      else $error("rising pin edge gave no count tick");

endmodule : ctm_tick_gen

// ===== rtl/ctm_core.sv
`timescale 1ns/10ps
// Behaviour
// - Counter compared with each comparator; equality raises event, may clear, may drive pin.
// - Three-bit select picks system, high, sub clock ratio or external pin.
// - External pin selected: transitions on it are counted as events.
// - Separate match events for comparator A and comparator P.
// - External pin counts on rising or falling edge as configured.
// - One external clock input, one true output and one complement output.
// - Compare mode: on A match outputs go high, low or toggle.
// - PWM mode drives its waveform on the same two outputs.
// - Counter and compare read as byte pairs; low byte through shared buffer.
// - Low write fills buffer only; compare high write stores high and copies buffer.
// - High read returns high and captures low into buffer for later read.
// - Modes: compare match output, timer/event counter, PWM output.
// - Core is a ten-bit up-only counter on the selected clock.
// - P compares three bits with counter top bits; A compares all ten.
// - Counter not writable; besides overflow and clear match, cleared only by on-control rising.
// - Counter clears on overflow or selected comparator match.
// - Period zero means full 1024-clock period via overflow.
// - Outside PWM, clear select zero clears on P match, one on A match; PWM uses the swap bit.
// - On-control rising in compare mode returns output to configured initial level.
module ctm_core
   import ctm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Internal clock strobes
   input wire logic high_clk_tick,
   input wire logic sub_clk_tick,
   // Timer pins
   input wire logic compact_ext_clock_pin,
   output logic compact_output_true,
   output logic compact_output_complement,
   // Match events
   output logic compare_a_event,
   output logic compare_p_event
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ctm_ctrl0_t ctrl0_reg;
   ctm_ctrl1_t ctrl1_reg;
   logic [9:0] cnt_reg;
   logic [9:0] cmpa_reg;
   logic [7:0] buf_reg;
   logic [7:0] snap_reg;
   logic on_prev_reg;
   logic a_prev_reg;
   logic p_prev_reg;
   logic out_level_reg;
   logic count_tick;
   logic on_rise;
   logic run;
   logic a_hit;
   logic p_hit;
   logic clr_hit;
   logic wrap;
   logic clr_src;
   logic setup;
   logic access;
   logic mapped;
   logic wr_acc;
   logic rd_acc;
   logic pwm_active;
   logic [31:0] rd_next;

   // High byte of a ten-bit value, zero padded
   function automatic logic [31:0] hi_byte(input logic [9:0] v);
      hi_byte = {30'h0000_0000, v[9:8]};
   endfunction : hi_byte

   // ----------------------------------------------------------------
   // Clock source
   // ----------------------------------------------------------------
   ctm_tick_gen ctm_tick_gen_inst (
      .pclk(pclk),
      .presetn(presetn),
      .clk_sel(ctrl0_reg.clk_sel),
      .high_clk_tick(high_clk_tick),
      .sub_clk_tick(sub_clk_tick),
      .compact_ext_clock_pin(compact_ext_clock_pin),
      .count_tick(count_tick)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states keeps the byte-pair sequence simple for software
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign pready = 1'b1;
   assign mapped = (paddr == CTM_OFS_CTRL0) || (paddr == CTM_OFS_CTRL1) ||
                   (paddr == CTM_OFS_CNT_LO) || (paddr == CTM_OFS_CNT_HI) ||
                   (paddr == CTM_OFS_CMPA_LO) || (paddr == CTM_OFS_CMPA_HI);
   assign pslverr = access & ~mapped;
   assign wr_acc = access & pwrite & mapped;
   assign rd_acc = access & ~pwrite & mapped;

   // Read multiplexer; low bytes always come from the buffer
   always_comb
   begin
      rd_next = 32'h0000_0000;
      if (paddr == CTM_OFS_CTRL0)
         rd_next = {24'h00_0000, ctrl0_reg};
      else if (paddr == CTM_OFS_CTRL1)
         rd_next = {24'h00_0000, ctrl1_reg};
      else if ((paddr == CTM_OFS_CNT_LO) || (paddr == CTM_OFS_CMPA_LO))
         rd_next = {24'h00_0000, buf_reg};
      else if (paddr == CTM_OFS_CNT_HI)
         rd_next = hi_byte(cnt_reg);
      else if (paddr == CTM_OFS_CMPA_HI)
         rd_next = hi_byte(cmpa_reg);
   end

   // Read data and low-byte snapshot taken in the setup cycle
   // so that the high and low halves come from the same count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         snap_reg <= 8'h00;
      end
      else if (setup && !pwrite)
      begin
         prdata <= rd_next;
         snap_reg <= (paddr == CTM_OFS_CNT_HI) ? cnt_reg[7:0] : cmpa_reg[7:0];
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl0_reg <= ctm_ctrl0_t'(CTM_CTRL_RST);
         ctrl1_reg <= ctm_ctrl1_t'(CTM_CTRL_RST);
      end
      else if (wr_acc)
      begin
         if (paddr == CTM_OFS_CTRL0)
            ctrl0_reg <= ctm_ctrl0_t'(pwdata[7:0]);
         if (paddr == CTM_OFS_CTRL1)
            ctrl1_reg <= ctm_ctrl1_t'(pwdata[7:0]);
      end
   end

   // Shared low-byte buffer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buf_reg <= 8'h00;
      else if (wr_acc && ((paddr == CTM_OFS_CMPA_LO) || (paddr == CTM_OFS_CNT_LO)))
         buf_reg <= pwdata[7:0];
      else if (rd_acc && ((paddr == CTM_OFS_CNT_HI) || (paddr == CTM_OFS_CMPA_HI)))
         buf_reg <= snap_reg;
   end

   // Compare A value; the pair only moves on the high write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cmpa_reg <= CTM_CMPA_RST;
      else if (wr_acc && (paddr == CTM_OFS_CMPA_HI))
         cmpa_reg <= {pwdata[1:0], buf_reg};
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   assign on_rise = ctrl0_reg.on & ~on_prev_reg;
   assign run = ctrl0_reg.on & ~ctrl0_reg.pause;
   assign a_hit = ctrl0_reg.on && (cnt_reg == cmpa_reg);
   // Period zero never matches the top bits; overflow ends the period
   assign p_hit = ctrl0_reg.on && ((ctrl0_reg.period == 3'h0) ? (cnt_reg == CTM_CNT_MAX)
                  : (cnt_reg[9:7] == ctrl0_reg.period));
   assign wrap = (cnt_reg == CTM_CNT_MAX);
   // In PWM the duty/period swap also picks the period comparator
   assign clr_src = (ctrl1_reg.mode == CTM_MODE_PWM) ? ctrl1_reg.dpx : ctrl1_reg.clr_sel;
   assign clr_hit = clr_src ? a_hit : p_hit;

   // On-control edge tracker
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         on_prev_reg <= 1'b0;
      else
         on_prev_reg <= ctrl0_reg.on;
   end

   // Up-only count; no bus path writes it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_reg <= 10'h000;
      else if (on_rise)
         cnt_reg <= 10'h000;
      else if (count_tick && run)
      begin
         if (wrap || clr_hit)
            cnt_reg <= 10'h000;
         else
            cnt_reg <= cnt_reg + 10'h001;
      end
   end

   // ----------------------------------------------------------------
   // Match events
   // ----------------------------------------------------------------
   // Edge of the equality so a stalled counter does not re-fire
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_prev_reg <= 1'b0;
         p_prev_reg <= 1'b0;
         compare_a_event <= 1'b0;
         compare_p_event <= 1'b0;
      end
      else
      begin
         a_prev_reg <= a_hit;
         p_prev_reg <= p_hit;
         compare_a_event <= a_hit & ~a_prev_reg;
         compare_p_event <= p_hit & ~p_prev_reg;
      end
   end

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   assign pwm_active = ctrl1_reg.dpx ? (cnt_reg < {ctrl0_reg.period, 7'h00}) : (cnt_reg < cmpa_reg);

   // Output level before polarity; timer mode just holds it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_level_reg <= 1'b0;
      else if (ctrl1_reg.mode == CTM_MODE_PWM)
      begin
         unique case (ctrl1_reg.io)
            2'h1: out_level_reg <= ctrl1_reg.init_level;
            2'h2: out_level_reg <= pwm_active ? ctrl1_reg.init_level : ~ctrl1_reg.init_level;
            default: out_level_reg <= ~ctrl1_reg.init_level;
         endcase
      end
      else if (ctrl1_reg.mode == CTM_MODE_CMP)
      begin
         if (on_rise)
            out_level_reg <= ctrl1_reg.init_level;
         else if (compare_a_event)
         begin
            unique case (ctrl1_reg.io)
               CTM_IO_KEEP: out_level_reg <= out_level_reg;
               CTM_IO_LOW: out_level_reg <= 1'b0;
               CTM_IO_HIGH: out_level_reg <= 1'b1;
               CTM_IO_TOGGLE: out_level_reg <= ~out_level_reg;
            endcase
         end
      end
   end

   // Polarity applies in every mode except timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compact_output_true <= 1'b0;
         compact_output_complement <= 1'b1;
      end
      else
      begin
         compact_output_true <= out_level_reg ^ (ctrl1_reg.invert &&
                                (ctrl1_reg.mode != CTM_MODE_TIMER));
         compact_output_complement <= ~(out_level_reg ^ (ctrl1_reg.invert &&
                                      (ctrl1_reg.mode != CTM_MODE_TIMER)));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence wr_cmpa_lo_s;
      setup && pwrite && (paddr == CTM_OFS_CMPA_LO) ##1 access;
   endsequence

   sequence rd_cnt_hi_s;
      setup && !pwrite && (paddr == CTM_OFS_CNT_HI) ##1 access;
   endsequence

   event_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      compare_a_event |=> !compare_a_event)
      else $error("compare A event longer than one cycle");

   on_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      on_rise |=> (cnt_reg == 10'h000))
      else $error("counter not cleared when turned on");

   wrap_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_tick && run && !on_rise && wrap |=> (cnt_reg == 10'h000))
      else $error("counter did not wrap to zero");

   count_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_tick && run && !on_rise && !wrap && !clr_hit |=> (cnt_reg == $past(cnt_reg) + 10'h001))
      else $error("counter did not step by one");

   low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cmpa_lo_s |=> (cmpa_reg == $past(cmpa_reg)) && (buf_reg == $past(pwdata[7:0])))
      else $error("low write touched compare value");

   high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_cnt_hi_s |=> (buf_reg == $past(cnt_reg[7:0], 2)))
      else $error("high read did not capture low byte");

   set_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl1_reg.mode == CTM_MODE_CMP) && compare_a_event && !on_rise &&
      (ctrl1_reg.io == CTM_IO_HIGH) |=> out_level_reg)
      else $error("compare match did not drive output high");

   pins_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      compact_output_complement == ~compact_output_true)
      else $error("complement output not inverse of true output");

   p_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_tick && run && !on_rise && !clr_src && p_hit |=> (cnt_reg == 10'h000))
      else $error("period match did not clear counter");

endmodule : ctm_core

// ===== bench/compact_timer_core_bench.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Compact timer bench
// ----------------------------------------------------------------
module compact_timer_core_bench;
   import ctm_pkg::*;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic high_clk_tick = 1'b0;
   logic sub_clk_tick = 1'b0;
   logic compact_ext_clock_pin = 1'b0;
   logic compact_output_true;
   logic compact_output_complement;
   logic compare_a_event;
   logic compare_p_event;
   logic [2:0] tick_div = 3'h0;
   int err_count = 0;
   int check_count = 0;
   int a_cnt = 0;
   int p_cnt = 0;
   int comp_bad = 0;

   ctm_core ctm_core_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .high_clk_tick(high_clk_tick), .sub_clk_tick(sub_clk_tick),
      .compact_ext_clock_pin(compact_ext_clock_pin), .compact_output_true(compact_output_true),
      .compact_output_complement(compact_output_complement),
      .compare_a_event(compare_a_event), .compare_p_event(compare_p_event)
   );

   // Clock at 10 MHz
   always #50 pclk = ~pclk;

   // Internal source strobes: high clock every 2 cycles, sub clock every 8
   always @(posedge pclk)
   begin
      tick_div <= tick_div + 3'h1;
      high_clk_tick <= tick_div[0];
      sub_clk_tick <= (tick_div == 3'h7);
   end

   // Event counters and complement watch; pulses are counted once per cycle seen high
   always @(posedge pclk)
   begin
      if (compare_a_event === 1'b1) a_cnt++;
      if (compare_p_event === 1'b1) p_cnt++;
      if (presetn === 1'b1 && compact_output_complement !== ~compact_output_true) comp_bad++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; request held until pready is sampled high
   task automatic apb_xfer(input logic is_wr, input logic [7:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) err_count++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next setup never lands in the release time step
      @(posedge pclk);
   endtask : apb_xfer

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic [31:0] d;
      logic e;
      apb_xfer(1'b1, addr, {24'h00_0000, data}, d, e);
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [31:0] data);
      logic e;
      apb_xfer(1'b0, addr, 32'h0000_0000, data, e);
   endtask : rd

   // Control byte 0 order: pause, source, on, period
   task automatic ctrl0(input logic [2:0] ck, input logic on, input logic [2:0] per);
      wr(CTM_OFS_CTRL0, {1'b0, ck, on, per});
   endtask : ctrl0

   // Control byte 1 order: mode, action, initial level, invert, swap, clear select
   task automatic ctrl1(input ctm_mode_t m, input logic [1:0] io, input logic init, input logic clr);
      wr(CTM_OFS_CTRL1, {m, io, init, 1'b0, 1'b0, clr});
   endtask : ctrl1

   // High byte first, then the buffered low byte
   task automatic rd_pair(input logic [7:0] hi_ofs, output logic [9:0] v);
      logic [31:0] h;
      logic [31:0] l;
      rd(hi_ofs, h);
      rd(hi_ofs - 8'h04, l);
      v = {h[1:0], l[7:0]};
   endtask : rd_pair

   // The pin is taken as already routed to the timer by the pin-sharing setup
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         compact_ext_clock_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         compact_ext_clock_pin <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask : ext_pulses

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Watchdog: the sequence needs about 6500 cycles
   // ----------------------------------------------------------------
   initial
   begin
      repeat (40000) @(posedge pclk);
      err_count++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic e;
      logic [9:0] v;
      int a0;
      int p0;
      int hi;
      int ex;
      logic [1:0] io;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset state and an unmapped address
      check("output after reset", {compact_output_true, compact_output_complement}, 2'b01);
      rd(CTM_OFS_CTRL0, d);
      check("control 0 reset", d, CTM_CTRL_RST);
      rd(CTM_OFS_CTRL1, d);
      check("control 1 reset", d, CTM_CTRL_RST);
      apb_xfer(1'b0, 8'h18, 32'h0000_0000, d, e);
      check("unmapped error", e, 1'b1);
      check("unmapped data", d, 32'h0000_0000);
      // Compare A pair: a lone low write must not reach the stored low byte
      wr(CTM_OFS_CMPA_LO, 8'hA5);
      wr(CTM_OFS_CMPA_HI, 8'h02);
      wr(CTM_OFS_CMPA_LO, 8'h33);
      rd_pair(CTM_OFS_CMPA_HI, v);
      check("compare A pair", v, 10'h2A5);
      rd_pair(CTM_OFS_CMPA_HI, v);
      check("compare A reread", v, 10'h2A5);
      // Counter is read only
      wr(CTM_OFS_CNT_LO, 8'h55);
      wr(CTM_OFS_CNT_HI, 8'h03);
      rd_pair(CTM_OFS_CNT_HI, v);
      check("counter write ignored", v, 10'h000);
      // Every internal clock source (codes 0 to 5) over a 512-cycle on window
      for (int ck = 0; ck < 6; ck++)
      begin
         case (ck)
            0: ex = 512 / CTM_SYS_DIV;
            1: ex = 512;
            2: ex = 256 / CTM_HI_DIV_A;
            3: ex = 256 / CTM_HI_DIV_B;
            default: ex = 64;
         endcase
         ctrl0(ck[2:0], 1'b1, 3'h0);
         repeat (509) @(posedge pclk);
         ctrl0(ck[2:0], 1'b0, 3'h0);
         rd_pair(CTM_OFS_CNT_HI, v);
         check("clock source count", (int'(v) >= ex - 3 - ex / 32) && (int'(v) <= ex + 3 + ex / 32), 1'b1);
      end
      // External pin, rising then falling edge; each switch-on restarts from zero
      ctrl0(CTM_CK_EXT_R, 1'b1, 3'h0);
      ext_pulses(5);
      ctrl0(CTM_CK_EXT_R, 1'b0, 3'h0);
      rd_pair(CTM_OFS_CNT_HI, v);
      check("rising pin count", v, 10'h005);
      ctrl0(CTM_CK_EXT_F, 1'b0, 3'h0);
      ctrl0(CTM_CK_EXT_F, 1'b1, 3'h0);
      ext_pulses(3);
      ctrl0(CTM_CK_EXT_F, 1'b0, 3'h0);
      rd_pair(CTM_OFS_CNT_HI, v);
      check("falling pin count", v, 10'h003);
      // Compare match output, every action, A = 5 clearing the counter
      wr(CTM_OFS_CMPA_LO, 8'h05);
      wr(CTM_OFS_CMPA_HI, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         io = k[1:0];
         ctrl1(CTM_MODE_CMP, io, io == CTM_IO_LOW, 1'b1);
         ctrl0(CTM_CK_EXT_R, 1'b1, 3'h0);
         repeat (3) @(posedge pclk);
         check("initial level", compact_output_true, io == CTM_IO_LOW);
         a0 = a_cnt;
         ext_pulses(6);
         repeat (4) @(posedge pclk);
         check("match action", compact_output_true, io == CTM_IO_HIGH || io == CTM_IO_TOGGLE);
         check("A event once", a_cnt - a0, 1);
         ctrl0(CTM_CK_EXT_R, 1'b0, 3'h0);
         rd_pair(CTM_OFS_CNT_HI, v);
         check("cleared on A", v, 10'h000);
      end
      // Period compare 1 clears the counter, A = 5 also matches each period
      ctrl1(CTM_MODE_CMP, CTM_IO_KEEP, 1'b0, 1'b0);
      a0 = a_cnt;
      p0 = p_cnt;
      ctrl0(CTM_CK_SYS, 1'b1, 3'h1);
      repeat (300) @(posedge pclk);
      check("P events", p_cnt - p0, 2);
      check("A events", a_cnt - a0, 3);
      // Period zero runs the full range before clearing
      ctrl0(CTM_CK_SYS, 1'b0, 3'h0);
      a0 = a_cnt;
      p0 = p_cnt;
      ctrl0(CTM_CK_SYS, 1'b1, 3'h0);
      repeat (1100) @(posedge pclk);
      check("full period P", p_cnt - p0, 1);
      check("full period A", a_cnt - a0, 2);
      ctrl0(CTM_CK_SYS, 1'b0, 3'h0);
      // PWM: period 129 from P, duty 32 from A, active high
      wr(CTM_OFS_CMPA_LO, 8'h20);
      wr(CTM_OFS_CMPA_HI, 8'h00);
      ctrl1(CTM_MODE_PWM, CTM_IO_HIGH, 1'b1, 1'b0);
      ctrl0(CTM_CK_SYS, 1'b1, 3'h1);
      repeat (20) @(posedge pclk);
      hi = 0;
      repeat (1290)
      begin
         @(posedge pclk);
         if (compact_output_true === 1'b1) hi++;
      end
      check("PWM high cycles", hi >= 300 && hi <= 340, 1'b1);
      // Timer mode: pin keeps the level set in compare mode; invert and action are ignored
      ctrl0(CTM_CK_SYS, 1'b0, 3'h1);
      ctrl1(CTM_MODE_CMP, CTM_IO_KEEP, 1'b1, 1'b0);
      ctrl0(CTM_CK_SYS, 1'b1, 3'h1);
      ctrl0(CTM_CK_SYS, 1'b0, 3'h1);
      wr(CTM_OFS_CTRL1, {CTM_MODE_TIMER, CTM_IO_TOGGLE, 1'b0, 1'b1, 1'b0, 1'b0});
      a0 = a_cnt;
      ctrl0(CTM_CK_SYS, 1'b1, 3'h1);
      repeat (200) @(posedge pclk);
      check("timer mode pin", compact_output_true, 1'b1);
      check("timer mode A events", a_cnt - a0, 2);
      // Reset in mid-run while the counter is running
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("output after second reset", {compact_output_true, compact_output_complement}, 2'b01);
      rd(CTM_OFS_CTRL0, d);
      check("control 0 after second reset", d, CTM_CTRL_RST);
      rd_pair(CTM_OFS_CNT_HI, v);
      check("counter after second reset", v, 10'h000);
      check("complement inverse", comp_bad, 0);
      complete_run();
   end

endmodule : compact_timer_core_bench
